// file: design/audio_serial_pkg.sv
/*
 Shared definitions for the audio serial port transmit block: register
 indices, reset values, field layouts, protocol and keeper codes.
 Assumes a 32-bit APB register bus, one word per register index.
*/
package audio_serial_pkg;

	// -------------------------------------------------------------------
	// Register map (index; byte address is four times the index)
	// -------------------------------------------------------------------
	localparam logic [7:0] IDX_FORMAT_CFG   = 8'h07;
	localparam logic [7:0] IDX_TX_CFG_B     = 8'h08;
	localparam logic [7:0] IDX_CTRL         = 8'h09;
	localparam logic [7:0] IDX_STATUS       = 8'h0A;
	localparam int         IDX_LSB          = 2;
	localparam int         IDX_MSB          = 9;

	localparam logic [7:0] FORMAT_CFG_RESET = 8'h30;
	localparam logic [7:0] TX_CFG_B_RESET   = 8'h00;
	localparam logic [7:0] CTRL_RESET       = 8'h00;

	// -------------------------------------------------------------------
	// Field codes
	// -------------------------------------------------------------------
	localparam logic [1:0] PROTO_TDM        = 2'h0;
	localparam logic [1:0] PROTO_I2S        = 2'h1;
	localparam logic [1:0] PROTO_LJ         = 2'h2;

	localparam logic [1:0] KEEP_OFF         = 2'h0;
	localparam logic [1:0] KEEP_ON          = 2'h1;
	localparam logic [1:0] KEEP_LSB_ONE     = 2'h2;
	localparam logic [1:0] KEEP_LSB_ONEHALF = 2'h3;

	// Keeper hold in bit-clock half cycles after the LSB launch
	localparam logic [1:0] KEEP_HALVES_ONE  = 2'h2;
	localparam logic [1:0] KEEP_HALVES_1P5  = 2'h3;

	localparam logic [5:0] LEN_16           = 6'h10;
	localparam logic [5:0] LEN_20           = 6'h14;
	localparam logic [5:0] LEN_24           = 6'h18;
	localparam logic [5:0] LEN_32           = 6'h20;

	// -------------------------------------------------------------------
	// Register, link output and transmit state layouts
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] protocol_select;
		logic [1:0] slot_word_length;
		logic       frame_sync_polarity;
		logic       bit_clock_polarity;
		logic       tx_launch_edge;
		logic       unused_fill;
	} format_cfg_type;

	typedef struct packed {
		logic       lsb_half;
		logic [1:0] keeper_mode;
		logic [4:0] msb_offset;
	} tx_cfg_b_type;

	typedef struct packed {
		logic [1:0] reserved;
		logic [4:0] last_slot;
		logic       enable;
	} ctrl_type;

	typedef struct packed {
		logic data;
		logic data_oe;
		logic keeper_en;
	} link_out_type;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_DELAY = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_type;

	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			2'h0:    word_bits = LEN_16;
			2'h1:    word_bits = LEN_20;
			2'h2:    word_bits = LEN_24;
			default: word_bits = LEN_32;
		endcase
	endfunction : word_bits

endpackage : audio_serial_pkg

// file: design/serial_tx_shifter.sv
/*
 MSB-first shift register for one slot word of programmable length.
 Assumes the caller loads and shifts only on bit launch events.
*/
`timescale 1ns/10ps
module serial_tx_shifter #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	// Control
	input  wire logic         load,
	input  wire logic         shift,
	input  wire logic [5:0]   wlen,
	input  wire logic [W-1:0] word,
	// Bit to launch now
	output logic              next_bit
);

	logic [W-1:0] sreg;
	logic [W-1:0] aligned;

	// Word sits in the low bits; move its MSB to the top
	assign aligned  = word << (6'(W) - wlen);
	assign next_bit = load ? aligned[W-1] : sreg[W-2];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sreg <= '0;
		else if (clk_en && load)
			sreg <= aligned;
		else if (clk_en && shift)
			sreg <= {sreg[W-2:0], 1'b0};
	end

endmodule : serial_tx_shifter

// file: design/audio_serial_tx.sv
/*
 Transmit side of the audio serial port: configuration registers on APB,
 frame timing from an external bit clock and frame sync, and the serial
 data pin with its enable and bus keeper control.
 Assumes bit clock and frame sync come from outside the pclk domain and
 are much slower than pclk; slot words come from logic on pclk.
*/
`timescale 1ns/10ps
module audio_serial_tx
	import audio_serial_pkg::*;
#(
	parameter int SLOT_W = 5,
	parameter int WORD_W = 32
) (
	// Clock, reset, clock enable
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   clk_en,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Serial link
	input  wire logic                   bit_clock,
	input  wire logic                   frame_sync,
	output audio_serial_pkg::link_out_type link_out,
	// Slot words
	input  wire logic [WORD_W-1:0]      slot_word,
	output logic                        word_taken,
	output logic      [SLOT_W-1:0]      word_slot
);

	format_cfg_type fmt;
	tx_cfg_b_type   cfgb;
	ctrl_type       ctrl;
	tx_state_type   state;
	tx_state_type   next_state;

	// -------------------------------------------------------------------
	// APB register access
	// -------------------------------------------------------------------
	logic [7:0] idx;
	logic       mapped;
	logic       wr_en;
	logic [31:0] rd_word;

	assign idx    = paddr[IDX_MSB:IDX_LSB];
	assign mapped = (paddr[IDX_LSB-1:0] == '0) &&
			(idx == IDX_FORMAT_CFG || idx == IDX_TX_CFG_B ||
			 idx == IDX_CTRL || idx == IDX_STATUS);
	assign wr_en  = psel && penable && pready && pwrite && mapped &&
			pstrb[0];

	logic [SLOT_W-1:0] slot;

	always_comb
	begin
		rd_word = '0;
		case (idx)
			IDX_FORMAT_CFG: rd_word[7:0] = fmt;
			IDX_TX_CFG_B:   rd_word[7:0] = cfgb;
			IDX_CTRL:       rd_word[7:0] = ctrl;
			IDX_STATUS:     rd_word[7:0] = {1'b0, 2'(state), slot};
			default:        rd_word = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite && mapped) ?
					rd_word : '0;
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fmt  <= format_cfg_type'(FORMAT_CFG_RESET);
			cfgb <= tx_cfg_b_type'(TX_CFG_B_RESET);
			ctrl <= ctrl_type'(CTRL_RESET);
		end
		else if (clk_en && wr_en)
		begin
			case (idx)
				IDX_FORMAT_CFG: fmt  <= format_cfg_type'(pwdata[7:0]);
				IDX_TX_CFG_B:   cfgb <= tx_cfg_b_type'(pwdata[7:0]);
				IDX_CTRL:       ctrl <= ctrl_type'(pwdata[7:0]);
				default:        ctrl <= ctrl;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Link input synchronisers and edge detection
	// -------------------------------------------------------------------
	logic [1:0] s1;
	logic [1:0] s2;
	logic [1:0] s3;
	logic [1:0] agreed;
	logic       fs_last;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1     <= '0;
			s2     <= '0;
			s3     <= '0;
			agreed <= '0;
		end
		else if (clk_en)
		begin
			s1 <= {frame_sync, bit_clock};
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < 2; i++)
				if (s2[i] == s3[i])
					agreed[i] <= s3[i];
		end
	end

	logic clk_change;
	logic rise_ev;
	logic fall_ev;
	logic fs_eff;
	logic launch;
	logic other_edge;
	logic is_tdm;
	logic framed;

	assign clk_change = (s2[0] == s3[0]) && (s3[0] != agreed[0]);
	assign rise_ev    = clk_change && (s3[0] ^ fmt.bit_clock_polarity);
	assign fall_ev    = clk_change && !(s3[0] ^ fmt.bit_clock_polarity);
	// I2S frames start on the falling sync; fold that into the polarity
	assign fs_eff     = agreed[1] ^ fmt.frame_sync_polarity ^
			(fmt.protocol_select == PROTO_I2S);
	assign launch     = fmt.tx_launch_edge ? rise_ev : fall_ev;
	assign other_edge = fmt.tx_launch_edge ? fall_ev : rise_ev;
	assign is_tdm     = fmt.protocol_select == PROTO_TDM;
	assign framed     = ctrl.enable && fmt.protocol_select != 2'h3;

	logic pending;
	logic pending_half;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fs_last      <= 1'b0;
			pending      <= 1'b0;
			pending_half <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rise_ev)
				fs_last <= fs_eff;
			if (rise_ev && framed && fs_eff && !fs_last)
			begin
				pending      <= 1'b1;
				pending_half <= 1'b0;
			end
			else if (rise_ev && framed && !is_tdm && !fs_eff && fs_last)
			begin
				pending      <= 1'b1;
				pending_half <= 1'b1;
			end
			else if (launch || !framed)
				pending <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Slot sequencing on launch edges
	// -------------------------------------------------------------------
	logic [5:0]        wlen;
	logic [5:0]        delay;
	logic [5:0]        cnt;
	logic [5:0]        next_cnt;
	logic [SLOT_W-1:0] next_slot;
	logic              load;
	logic              shift;
	logic              drive;
	logic              last;
	logic              tx_bit;

	assign wlen  = word_bits(fmt.slot_word_length);
	assign delay = {1'b0, cfgb.msb_offset} +
			6'(fmt.protocol_select == PROTO_I2S);

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		next_slot  = slot;
		load       = 1'b0;
		shift      = 1'b0;
		drive      = 1'b0;
		last       = 1'b0;
		if (pending)
		begin
			next_slot = SLOT_W'(pending_half);
			if (delay == '0)
			begin
				load       = 1'b1;
				drive      = 1'b1;
				next_cnt   = wlen - 6'h01;
				next_state = TX_SHIFT;
			end
			else
			begin
				next_cnt   = delay - 6'h01;
				next_state = TX_DELAY;
			end
		end
		else
		begin
			case (state)
				TX_DELAY:
					if (cnt == '0)
					begin
						load       = 1'b1;
						drive      = 1'b1;
						next_cnt   = wlen - 6'h01;
						next_state = TX_SHIFT;
					end
					else
						next_cnt = cnt - 6'h01;
				TX_SHIFT:
					if (cnt != '0)
					begin
						shift    = 1'b1;
						drive    = 1'b1;
						last     = cnt == 6'h01;
						next_cnt = cnt - 6'h01;
					end
					else if (is_tdm && slot < ctrl.last_slot)
					begin
						load       = 1'b1;
						drive      = 1'b1;
						next_slot  = slot + 1'b1;
						next_cnt   = wlen - 6'h01;
					end
					else
						next_state = TX_IDLE;
				default:
					next_state = TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= TX_IDLE;
			cnt   <= '0;
			slot  <= '0;
		end
		else if (clk_en && !framed)
			state <= TX_IDLE;
		else if (clk_en && launch)
		begin
			state <= next_state;
			cnt   <= next_cnt;
			slot  <= next_slot;
		end
	end

	serial_tx_shifter #(
		.W        (WORD_W)
	) u_shifter (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.load     (launch && framed && load),
		.shift    (launch && framed && shift),
		.wlen     (wlen),
		.word     (slot_word),
		.next_bit (tx_bit)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_taken <= 1'b0;
			word_slot  <= '0;
		end
		else if (clk_en)
		begin
			word_taken <= launch && framed && load;
			if (launch && framed && load)
				word_slot <= next_slot;
		end
	end

	// -------------------------------------------------------------------
	// Data pin, enable and keeper
	// -------------------------------------------------------------------
	logic       lsb_live;
	logic [1:0] keep_cnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_out.data    <= 1'b0;
			link_out.data_oe <= 1'b0;
			lsb_live         <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!framed)
			begin
				link_out.data    <= 1'b0;
				link_out.data_oe <= 1'b0;
				lsb_live         <= 1'b0;
			end
			else if (launch)
			begin
				link_out.data    <= drive && tx_bit;
				link_out.data_oe <= drive || !fmt.unused_fill;
				lsb_live         <= last;
			end
			else if (other_edge && lsb_live && cfgb.lsb_half)
				link_out.data_oe <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			keep_cnt           <= '0;
			link_out.keeper_en <= 1'b0;
		end
		else if (clk_en)
		begin
			if (launch && framed && last)
				keep_cnt <= (cfgb.keeper_mode == KEEP_LSB_ONE) ?
						KEEP_HALVES_ONE :
					(cfgb.keeper_mode == KEEP_LSB_ONEHALF) ?
						KEEP_HALVES_1P5 : '0;
			else if ((rise_ev || fall_ev) && keep_cnt != '0)
				keep_cnt <= keep_cnt - 2'h1;
			link_out.keeper_en <= (cfgb.keeper_mode == KEEP_ON) ||
					(keep_cnt != '0);
		end
	end

endmodule : audio_serial_tx

// file: tb/audio_serial_tx_checker.sv
/*
 Port checks for the audio serial transmitter, bound to its top module.
 Assumes one pclk domain with presetn as its reset.
*/
`timescale 1ns/10ps
module audio_serial_tx_checker
	import audio_serial_pkg::*;
#(
	parameter int SLOT_W = 5
) (
	// Clock, reset, bus
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic [11:0]                   paddr,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	// Link and words
	input wire audio_serial_pkg::link_out_type link_out,
	input wire logic                          word_taken,
	input wire logic [SLOT_W-1:0]             word_slot
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_misalign_err: assert property
		(psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	a_unmapped_err: assert property (psel && !penable &&
		(paddr[9:2] < IDX_FORMAT_CFG || paddr[9:2] > IDX_STATUS) |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'h0 &&
		paddr[9:2] >= IDX_FORMAT_CFG && paddr[9:2] <= IDX_STATUS |=> !pslverr)
		else $error("mapped access refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_taken_pulse: assert property (word_taken |=> (!word_taken)[*8])
		else $error("word taken too often");
	a_reset_quiet: assert property
		($rose(presetn) |-> link_out == 3'h0 && !word_taken && !pready)
		else $error("outputs not quiet after reset");

	cover property (pslverr);
	cover property (word_taken && word_slot == '0);
	cover property (link_out.keeper_en);
endmodule : audio_serial_tx_checker

bind audio_serial_tx audio_serial_tx_checker #(.SLOT_W(SLOT_W)) chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.link_out(link_out), .word_taken(word_taken), .word_slot(word_slot)
);

// file: tb/host_rx_model.sv
/*
 Host receiver model: makes bit clock and frame sync, samples the data pin.
 Assumes launched data settles within 60 ns of a bit clock edge.
*/
`timescale 1ns/10ps
module host_rx_model
(
	// Link
	output logic                               bit_clock,
	output logic                               frame_sync,
	input  wire audio_serial_pkg::link_out_type link_out
);
	import audio_serial_pkg::*;

	logic [63:0] cap;
	logic [63:0] cap2;
	int          oe_cnt;
	int          kp_cnt;

	initial
	begin
		bit_clock = 1'b0;
		frame_sync = 1'b0;
	end

	// Two idle bits, then k + 1 bits with sync active; clock stops after
	task automatic run_frame(input int k, input logic act, input logic inv);
		int j;
		cap = 64'h0;
		cap2 = 64'h0;
		oe_cnt = 0;
		kp_cnt = 0;
		frame_sync = ~act;
		bit_clock = inv;
		for (j = 0; j < k + 3; j++)
		begin
			#1 bit_clock = ~inv;
			#60;
			if (j > 2)
			begin
				cap = {cap[62:0], link_out.data & link_out.data_oe};
				oe_cnt += int'(link_out.data_oe);
				kp_cnt += int'(link_out.keeper_en);
			end
			#2.5 bit_clock = inv;
			if (j == 1)
				frame_sync = act;
			#60;
			if (j >= 2 && j < k + 2)
				cap2 = {cap2[62:0], link_out.data & link_out.data_oe};
			#1.5;
		end
		frame_sync = ~act;
	endtask : run_frame
endmodule : host_rx_model

// file: tb/audio_serial_tx_tb.sv
/*
 Testbench for the audio serial transmitter: APB tasks and frame cases.
 Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module audio_serial_tx_tb;
	import audio_serial_pkg::*;

	logic         pclk;
	logic         presetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [11:0]  paddr;
	logic [31:0]  pwdata;
	logic [3:0]   pstrb;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         bit_clock;
	logic         frame_sync;
	link_out_type link_out;
	logic         word_taken;
	logic [4:0]   word_slot;
	logic [31:0]  v;
	logic         er;
	int           errors;
	int           cmp_count;

	audio_serial_tx audio_serial_tx_i (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bit_clock(bit_clock), .frame_sync(frame_sync),
		.link_out(link_out), .slot_word(32'h0000A5C3),
		.word_taken(word_taken), .word_slot(word_slot)
	);
	host_rx_model host_rx_model_i (
		.bit_clock(bit_clock), .frame_sync(frame_sync), .link_out(link_out)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic compare(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : compare

	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
		input logic s, output logic [31:0] rd, output logic ev);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= {3'h0, s};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic ee);
		apb(a, 1'b0, 8'h00, 1'b1, v, er);
		compare(64'(v), {56'h0, e});
		compare(64'(er), {63'h0, ee});
	endtask : rd

	// Expected bits: word shifted by the MSB delay, LSB lost if half driven
	task automatic run_case(input logic [7:0] fmt, input logic [7:0] cfgb,
		input logic act, input logic inv, input int d, input logic lag);
		logic [63:0] e;
		logic [63:0] e2;
		int          kp;
		apb(12'h01C, 1'b1, fmt, 1'b1, v, er);
		apb(12'h020, 1'b1, cfgb, 1'b1, v, er);
		e = 64'(16'hA5C3 - 16'(cfgb[7])) << (4 - d);
		// Half-driven LSB still stands in the first half cycle
		e2 = 64'(16'hA5C3) << (4 - d);
		kp = (cfgb[6:5] == KEEP_ON) ? 20 : (cfgb[6:5] == KEEP_LSB_ONE) ? 1 : 0;
		host_rx_model_i.run_frame(20, act, inv);
		compare(host_rx_model_i.cap, e);
		compare(host_rx_model_i.cap2, lag ? e2 >> 1 : e2);
		compare(64'(word_slot), 64'h0);
		compare(64'(host_rx_model_i.oe_cnt), 64'((fmt[0] ? 16 : 20) - cfgb[7]));
		compare(64'(host_rx_model_i.kp_cnt), 64'(kp));
		$display("case fmt %0h cfg %0h done", fmt, cfgb);
	endtask : run_case

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#200000;
		errors++;
		report_and_stop();
	end

	initial
	begin
		errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h01C, 8'h30, 1'b0);
		rd(12'h020, 8'h00, 1'b0);
		apb(12'h020, 1'b1, 8'hFF, 1'b1, v, er);
		apb(12'h020, 1'b1, 8'h00, 1'b0, v, er);
		rd(12'h020, 8'hFF, 1'b0);
		rd(12'h040, 8'h00, 1'b1);
		rd(12'h022, 8'h00, 1'b1);
		apb(12'h024, 1'b1, 8'h01, 1'b1, v, er);
		$display("register tests done");
		run_case(8'h00, 8'h00, 1'b1, 1'b0, 0, 1'b0);
		run_case(8'h00, 8'h03, 1'b1, 1'b0, 3, 1'b0);
		run_case(8'h40, 8'h00, 1'b0, 1'b0, 1, 1'b0);
		run_case(8'h80, 8'h00, 1'b1, 1'b0, 0, 1'b0);
		run_case(8'h08, 8'h00, 1'b0, 1'b0, 0, 1'b0);
		run_case(8'h04, 8'h00, 1'b1, 1'b1, 0, 1'b0);
		run_case(8'h02, 8'h00, 1'b1, 1'b0, 0, 1'b1);
		run_case(8'h01, 8'h00, 1'b1, 1'b0, 0, 1'b0);
		run_case(8'h00, 8'h80, 1'b1, 1'b0, 0, 1'b0);
		run_case(8'h00, 8'h20, 1'b1, 1'b0, 0, 1'b0);
		run_case(8'h00, 8'h40, 1'b1, 1'b0, 0, 1'b0);
		report_and_stop();
	end
endmodule : audio_serial_tx_tb
